// ==== hw/rbs_top.v ====
// reset and boot sequencer top with axi-lite status and host control
`include "rbs_defines.vh"
module rbs_top (
    input wire core_clk,
    input wire rstn,
    input wire test_clock,
    input wire test_rstn_pin,
    input wire test_rstn_driven,
    input wire [1:0] scan_mode_pins,
    input wire [1:0] boot_mode_cfg,
    input wire pci_boot_sel,
    input wire big_endian,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] rom_rd_addr_q,
    output reg rom_rd_req_q,
    input wire rom_rd_ack,
    input wire [7:0] rom_rd_byte,
    output reg [31:0] mem_wr_addr_q,
    output reg [31:0] mem_wr_data_q,
    output reg mem_wr_req_q,
    input wire mem_wr_ack,
    output reg cpu_stall_q,
    output reg cpu_run_q,
    output reg [31:0] cpu_pc_q,
    output reg host_mem_en_q,
    output reg host_port_pci_q,
    output reg host_irq_q,
    output reg test_rstn_q,
    output reg [1:0] scan_mode_q,
    output reg boundary_scan_q
);
    localparam ST_RESET = 2'd0;
    localparam ST_STALL = 2'd1;
    localparam ST_COPY = 2'd2;
    localparam ST_RUN = 2'd3;

    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [1:0] boot_mode_q;
    reg released_q;
    reg flag_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg trst_s1_q;
    reg valid_s1_q;
    reg valid_s2_q;
    wire trst_sync;
    wire [1:0] scan_sync;
    wire scan_valid;
    wire [31:0] copy_rd_addr;
    wire copy_rd_req;
    wire [31:0] copy_wr_addr;
    wire [31:0] copy_wr_data;
    wire copy_wr_req;
    wire copy_done;
    wire copy_start;
    wire wr_fire;
    wire flag_set;
    wire flag_clr;
    // an undriven pin reads low, as the pull-down would make it
    wire trst_pin_eff = test_rstn_driven & test_rstn_pin;

    // test logic has its own reset path, independent of chip reset
    rbs_test_reset u_trst (
        .test_clock(test_clock),
        .test_rstn_pin(trst_pin_eff),
        .chip_released(released_q),
        .scan_mode_pins(scan_mode_pins),
        .test_rstn_q(trst_sync),
        .scan_mode_q(scan_sync),
        .scan_latched_q(scan_valid)
    );

    assign copy_start = (st_q == ST_COPY);

    rbs_rom_copy u_copy (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(copy_start),
        .big_endian(big_endian),
        .rd_addr_q(copy_rd_addr),
        .rd_req_q(copy_rd_req),
        .rd_ack(rom_rd_ack),
        .rd_byte(rom_rd_byte),
        .wr_addr_q(copy_wr_addr),
        .wr_data_q(copy_wr_data),
        .wr_req_q(copy_wr_req),
        .wr_ack(mem_wr_ack),
        .done_q(copy_done)
    );

    // chip reset release marker and boot configuration capture
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            released_q <= 1'b0;
            boot_mode_q <= `RBS_BOOT_NONE;
            host_port_pci_q <= `RBS_HOST_PARALLEL;
        end else if (!released_q) begin
            released_q <= 1'b1;
            boot_mode_q <= boot_mode_cfg;
            host_port_pci_q <= pci_boot_sel;
        end
    end

    // boot sequence state choice
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_RESET: begin
                if (released_q) begin
                    if (boot_mode_q == `RBS_BOOT_HOST) begin
                        st_d = ST_STALL;
                    end else if (boot_mode_q == `RBS_BOOT_ROM) begin
                        st_d = ST_COPY;
                    end else begin
                        st_d = ST_RUN;
                    end
                end
            end
            ST_STALL: begin
                // only the host boot path listens to the flag
                if (flag_q) begin
                    st_d = ST_RUN;
                end
            end
            ST_COPY: begin
                if (copy_done) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: st_d = ST_RUN;
            default: st_d = ST_RESET;
        endcase
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // cpu control and host memory access window
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_stall_q <= 1'b1;
            cpu_run_q <= 1'b0;
            cpu_pc_q <= `RBS_RESET_VECTOR;
            host_mem_en_q <= 1'b0;
        end else begin
            cpu_stall_q <= (st_d != ST_RUN);
            cpu_run_q <= (st_d == ST_RUN);
            cpu_pc_q <= `RBS_RESET_VECTOR; // start at address 0
            host_mem_en_q <= (st_d == ST_STALL) || (st_d == ST_RUN);
        end
    end

    // forward copy engine traffic to the memory ports
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rom_rd_addr_q <= 32'h0000_0000;
            rom_rd_req_q <= 1'b0;
            mem_wr_addr_q <= 32'h0000_0000;
            mem_wr_data_q <= 32'h0000_0000;
            mem_wr_req_q <= 1'b0;
        end else begin
            rom_rd_addr_q <= copy_rd_addr;
            rom_rd_req_q <= copy_rd_req & ~rom_rd_ack;
            mem_wr_addr_q <= copy_wr_addr;
            mem_wr_data_q <= copy_wr_data;
            mem_wr_req_q <= copy_wr_req & ~mem_wr_ack;
        end
    end

    // test side levels cross through two flops; the scan word is taken
    // only after its latched flag has crossed, when it no longer moves
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trst_s1_q <= 1'b0;
            valid_s1_q <= 1'b0;
            valid_s2_q <= 1'b0;
            test_rstn_q <= 1'b0;
            scan_mode_q <= `RBS_SCAN_NORMAL;
            boundary_scan_q <= 1'b0;
        end else begin
            trst_s1_q <= trst_sync;
            test_rstn_q <= trst_s1_q;
            valid_s1_q <= scan_valid;
            valid_s2_q <= valid_s1_q;
            scan_mode_q <= valid_s2_q ? scan_sync : scan_mode_q;
            boundary_scan_q <= valid_s2_q &&
                (scan_sync == `RBS_SCAN_BOUNDARY);
        end
    end

    // axi-lite write: address and data accepted in either order
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign flag_set = wr_fire && (aw_addr_q == `RBS_ADDR_HOSTCTL) &&
        w_strb_q[0] && w_data_q[`RBS_HOSTCTL_FLAG_BIT];
    assign flag_clr = wr_fire && (aw_addr_q == `RBS_ADDR_CTRL) &&
        w_strb_q[0] && w_data_q[`RBS_CTRL_CPU_CLR_BIT] && cpu_run_q;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RBS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q == `RBS_ADDR_HOSTCTL ||
                    aw_addr_q == `RBS_ADDR_CTRL) ? `RBS_RESP_OKAY :
                    `RBS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    // host flag: set wins over clear; a set while already set is dropped
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
            host_irq_q <= 1'b0;
        end else begin
            if (flag_set) begin
                flag_q <= 1'b1;
            end else if (flag_clr) begin
                flag_q <= 1'b0;
            end
            // no interrupt for the boot flag, nor while it stays set
            host_irq_q <= flag_set && !flag_q && cpu_run_q;
        end
    end

    // axi-lite read path
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RBS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RBS_RESP_OKAY;
                case (s_axi_araddr[7:0])
                    `RBS_ADDR_CTRL: s_axi_rdata <= 32'h0000_0000;
                    `RBS_ADDR_STATUS: s_axi_rdata <= {24'h00_0000,
                        boot_mode_q, host_port_pci_q, st_q,
                        cpu_stall_q, released_q, copy_done};
                    `RBS_ADDR_HOSTCTL: s_axi_rdata <= {30'h0000_0000,
                        flag_q, 1'b0};
                    `RBS_ADDR_SCAN: s_axi_rdata <= {28'h000_0000,
                        valid_s2_q, test_rstn_q, scan_mode_q};
                    // variant field reads zero until chip release
                    `RBS_ADDR_IDCODE: s_axi_rdata <= (`RBS_IDCODE_BASE &
                        32'h0fff_ffff) |
                        {`RBS_IDCODE_VARIANT & {4{released_q}}, 28'h000_0000};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RBS_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // rbs_top

// ==== hw/rbs_defines.vh ====
// constants for the reset and boot sequencer
`ifndef RBS_DEFINES_VH
`define RBS_DEFINES_VH
// boot mode encodings of the boot mode configuration inputs
`define RBS_BOOT_NONE 2'h0
`define RBS_BOOT_HOST 2'h1
`define RBS_BOOT_ROM 2'h2
// host port select
`define RBS_HOST_PARALLEL 1'b0
`define RBS_HOST_PCI 1'b1
// scan mode pin decode
`define RBS_SCAN_BOUNDARY 2'h0
`define RBS_SCAN_NORMAL 2'h3
// rom copy: 1K-Byte from chip select space 1 to address 0
`define RBS_ROM_BYTES 11'h400
`define RBS_ROM_WORDS 9'h100
`define RBS_ROM_SRC_BASE 32'h9000_0000
`define RBS_DST_BASE 32'h0000_0000
`define RBS_RESET_VECTOR 32'h0000_0000
// axi-lite register map
`define RBS_ADDR_CTRL 8'h00
`define RBS_ADDR_STATUS 8'h04
`define RBS_ADDR_HOSTCTL 8'h08
`define RBS_ADDR_SCAN 8'h0c
`define RBS_ADDR_IDCODE 8'h10
// host control register fields
`define RBS_HOSTCTL_FLAG_BIT 1
// ctrl register fields
`define RBS_CTRL_CPU_CLR_BIT 0
// identity code; value is arbitrary
`define RBS_IDCODE_BASE 32'h0ab0_0001
`define RBS_IDCODE_VARIANT 4'h5
// axi responses
`define RBS_RESP_OKAY 2'h0
`define RBS_RESP_SLVERR 2'h2
`endif

// ==== hw/rbs_test_reset.v ====
// test-logic reset sampler and scan mode latch on the test clock
`include "rbs_defines.vh"
module rbs_test_reset (
    input wire test_clock,
    input wire test_rstn_pin,
    input wire chip_released,
    input wire [1:0] scan_mode_pins,
    output reg test_rstn_q,
    output reg [1:0] scan_mode_q,
    output reg scan_latched_q
);
    reg trst_meta_q;
    reg trst_prev_q;
    reg rel_meta_q;
    reg rel_q;

    // reset is sampled on the test clock; no edges, no release
    always @(posedge test_clock) begin
        trst_meta_q <= test_rstn_pin;
        test_rstn_q <= trst_meta_q;
        trst_prev_q <= test_rstn_q;
        rel_meta_q <= chip_released;
        rel_q <= rel_meta_q;
    end

    // latch scan pins on rising edge of test reset after chip release
    always @(posedge test_clock) begin
        // the word only moves while the latched flag is low, so the core
        // side can take it once the flag has crossed over
        if (!test_rstn_q) begin
            scan_latched_q <= 1'b0;
        end else if (test_rstn_q && !trst_prev_q && rel_q) begin
            scan_mode_q <= scan_mode_pins;
            scan_latched_q <= 1'b1;
        end
    end
endmodule // rbs_test_reset

// ==== hw/rbs_rom_copy.v ====
// rom boot copy engine: packs bytes into words and writes them to address 0
`include "rbs_defines.vh"
module rbs_rom_copy (
    input wire core_clk,
    input wire rstn,
    input wire start,
    input wire big_endian,
    output reg [31:0] rd_addr_q,
    output reg rd_req_q,
    input wire rd_ack,
    input wire [7:0] rd_byte,
    output reg [31:0] wr_addr_q,
    output reg [31:0] wr_data_q,
    output reg wr_req_q,
    input wire wr_ack,
    output reg done_q
);
    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_WRITE = 2'd2;
    localparam ST_DONE = 2'd3;
    reg [1:0] st_q;
    reg [10:0] cnt_q;
    reg [31:0] pack_q;

    // pack a byte into the word in the chosen endian order
    function [31:0] pack_byte;
        input [31:0] w;
        input [7:0] b;
        input [1:0] lane;
        input be;
        reg [1:0] sel;
        begin
            sel = be ? ~lane : lane;
            pack_byte = w;
            pack_byte[sel*8 +: 8] = b;
        end
    endfunction

    // single-frame block copy of 1K-Byte from space 1 to address 0
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            cnt_q <= 11'h000;
            pack_q <= 32'h0000_0000;
            rd_addr_q <= 32'h0000_0000;
            rd_req_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
            wr_data_q <= 32'h0000_0000;
            wr_req_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        st_q <= ST_READ;
                        rd_addr_q <= `RBS_ROM_SRC_BASE;
                        rd_req_q <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (rd_ack) begin
                        pack_q <= pack_byte(pack_q, rd_byte, cnt_q[1:0],
                            big_endian);
                        cnt_q <= cnt_q + 11'h001;
                        rd_addr_q <= rd_addr_q + 32'h0000_0001;
                        if (cnt_q[1:0] == 2'h3) begin
                            rd_req_q <= 1'b0;
                            wr_req_q <= 1'b1;
                            wr_addr_q <= `RBS_DST_BASE +
                                {21'h0, cnt_q[10:2], 2'h0};
                            wr_data_q <= pack_byte(pack_q, rd_byte,
                                cnt_q[1:0], big_endian);
                            st_q <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (wr_ack) begin
                        wr_req_q <= 1'b0;
                        if (cnt_q == `RBS_ROM_BYTES) begin
                            st_q <= ST_DONE;
                            done_q <= 1'b1;
                        end else begin
                            rd_req_q <= 1'b1;
                            st_q <= ST_READ;
                        end
                    end
                end
                ST_DONE: begin
                    done_q <= 1'b1;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // rbs_rom_copy

// ==== verification/rbs_checker.sv ====
// concurrent checks on the ports of the reset and boot sequencer top
`include "rbs_defines.vh"
module rbs_checker (
    input logic core_clk,
    input logic rstn,
    input logic cpu_stall_q,
    input logic cpu_run_q,
    input logic [31:0] cpu_pc_q,
    input logic rom_rd_req_q,
    input logic [31:0] rom_rd_addr_q,
    input logic rom_rd_ack,
    input logic mem_wr_req_q,
    input logic [31:0] mem_wr_addr_q,
    input logic [31:0] mem_wr_data_q,
    input logic mem_wr_ack,
    input logic host_irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // copy traffic and the two request waits of the copy engine
    sequence s_copy_busy;
        rom_rd_req_q || mem_wr_req_q;
    endsequence
    sequence s_rd_wait;
        rom_rd_req_q && !rom_rd_ack;
    endsequence
    sequence s_wr_wait;
        mem_wr_req_q && !mem_wr_ack;
    endsequence

    copy_stalls_cpu_a: assert property (
        s_copy_busy |-> cpu_stall_q && !cpu_run_q)
        else $error("copy traffic while cpu not stalled");
    rd_req_hold_a: assert property (
        s_rd_wait |=> rom_rd_req_q && $stable(rom_rd_addr_q))
        else $error("rom read dropped or moved before ack");
    wr_req_hold_a: assert property (
        s_wr_wait |=> mem_wr_req_q && $stable(mem_wr_data_q))
        else $error("packed word changed before ack");
    rd_in_space_a: assert property (
        rom_rd_req_q |-> rom_rd_addr_q - `RBS_ROM_SRC_BASE < 32'h0000_0400)
        else $error("rom read outside the first 1K of space 1");
    wr_to_zero_a: assert property (
        mem_wr_req_q |-> mem_wr_addr_q < 32'h0000_0400
            && mem_wr_addr_q[1:0] == 2'h0)
        else $error("copy write outside the 1K at address 0");
    run_from_zero_a: assert property (
        $rose(cpu_run_q) |-> cpu_pc_q == `RBS_RESET_VECTOR && !cpu_stall_q)
        else $error("cpu started away from address 0");
    run_sticks_a: assert property (
        cpu_run_q |=> cpu_run_q [*2])
        else $error("cpu fell back out of run");
    irq_when_run_a: assert property (
        host_irq_q |-> cpu_run_q ##1 !host_irq_q)
        else $error("host interrupt while stalled or stretched");
    stall_excl_a: assert property (
        cpu_stall_q |-> !cpu_run_q)
        else $error("cpu stalled and running at once");
endmodule // rbs_checker

bind rbs_top rbs_checker u_chk (.core_clk, .rstn, .cpu_stall_q, .cpu_run_q,
    .cpu_pc_q, .rom_rd_req_q, .rom_rd_addr_q, .rom_rd_ack, .mem_wr_req_q,
    .mem_wr_addr_q, .mem_wr_data_q, .mem_wr_ack, .host_irq_q);

// ==== verification/rbs_mem_model.sv ====
// external boot rom and main memory answering the copy engine
module rbs_mem_model (
    input logic clk,
    input logic rstn,
    input logic [1:0] delay,
    input logic [31:0] rd_addr,
    input logic rd_req,
    output logic rd_ack,
    output logic [7:0] rd_byte,
    input logic [31:0] wr_addr,
    input logic [31:0] wr_data,
    input logic wr_req,
    output logic wr_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255];
    logic [1:0] rd_cnt_q;
    logic [1:0] wr_cnt_q;

    // rom byte pattern, a function of the offset inside the space
    function automatic logic [7:0] rom_at(input logic [9:0] a);
        return a[7:0] ^ {a[9:8], 6'h15};
    endfunction

    // answer after the chosen wait; byte lines toggle when not answering
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_ack <= 1'b0;
            wr_ack <= 1'b0;
            rd_cnt_q <= 2'h0;
            wr_cnt_q <= 2'h0;
            rd_byte <= 8'h00;
        end else begin
            rd_ack <= 1'b0;
            wr_ack <= 1'b0;
            rd_byte <= ~rd_byte;
            if (rd_req && !rd_ack) begin
                rd_cnt_q <= rd_cnt_q + 2'h1;
                if (rd_cnt_q == delay) begin
                    rd_ack <= 1'b1;
                    rd_byte <= rom_at(rd_addr[9:0]);
                    rd_cnt_q <= 2'h0;
                end
            end
            if (wr_req && !wr_ack) begin
                wr_cnt_q <= wr_cnt_q + 2'h1;
                if (wr_cnt_q == delay) begin
                    wr_ack <= 1'b1;
                    mem[wr_addr[9:2]] <= wr_data;
                    wr_cnt_q <= 2'h0;
                end
            end
        end
    end
endmodule // rbs_mem_model

// ==== verification/rbs_top_tb.sv ====
// self-checking bench for the reset and boot sequencer
`include "rbs_defines.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module rbs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rstn = 0, test_clock = 0, test_rstn_pin = 0;
    logic test_rstn_driven = 0, pci_boot_sel = 0, big_endian = 0, sel;
    logic [1:0] scan_mode_pins = 0, boot_mode_cfg = 0, dly = 0, resp, sp;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [31:0] rd_val, exp_w;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, rom_rd_req_q, rom_rd_ack, mem_wr_req_q, mem_wr_ack;
    wire cpu_stall_q, cpu_run_q, host_mem_en_q, host_port_pci_q, host_irq_q;
    wire test_rstn_q, boundary_scan_q;
    wire [1:0] s_axi_bresp, s_axi_rresp, scan_mode_q;
    wire [31:0] s_axi_rdata, rom_rd_addr_q, mem_wr_addr_q, mem_wr_data_q;
    wire [31:0] cpu_pc_q;
    wire [7:0] rom_rd_byte;
    int num_errors = 0, checks_done = 0, cycles = 0, irq_cnt = 0;

    rbs_top i_dut (.*, .s_axi_wstrb(4'hf));
    rbs_mem_model i_mem (.clk(core_clk), .rstn, .delay(dly),
        .rd_addr(rom_rd_addr_q), .rd_req(rom_rd_req_q), .rd_ack(rom_rd_ack),
        .rd_byte(rom_rd_byte), .wr_addr(mem_wr_addr_q),
        .wr_data(mem_wr_data_q), .wr_req(mem_wr_req_q), .wr_ack(mem_wr_ack));

    always #5 core_clk = ~core_clk;

    // hang guard and host interrupt pulse counter
    always @(posedge core_clk) begin
        cycles++;
        if (host_irq_q === 1'b1) irq_cnt++;
        if (cycles == 40000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [7:0] rom_exp(input int a);
        return a[7:0] ^ {a[9:8], 6'h15};
    endfunction

    // 12-cycle chip reset with the configuration set up underneath
    task automatic boot(input logic [1:0] m, input logic be,
                        input logic [1:0] d);
        rstn <= 1'b0;
        boot_mode_cfg <= m;
        big_endian <= be;
        dly <= d;
        pci_boot_sel <= 1'($urandom);
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;  // clock runs well before release
        repeat (3) @(posedge core_clk);
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge core_clk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);  // an edge between two requests
    endtask

    task automatic axi_rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        rd_val = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);  // an edge between two requests
    endtask

    task automatic wait_run(input int lim);
        int n;
        n = 0;
        while (cpu_run_q !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    // test clock only runs while the controller is busy
    task automatic tck(input int n);
        repeat (n) begin
            #3 test_clock = 1'b1;
            #4 test_clock = 1'b0;
        end
    endtask

    initial begin
        void'($urandom(81));
        @(posedge core_clk);
        // no boot, test reset left to the pull-down
        boot(`RBS_BOOT_NONE, 1'b0, 2'h0);  // both resets low
        `CHK(cpu_run_q, 1'b1)
        `CHK(cpu_stall_q, 1'b0)
        `CHK(rom_rd_req_q, 1'b0)
        axi_rd(`RBS_ADDR_IDCODE);
        `CHK(rd_val[31:28], `RBS_IDCODE_VARIANT)
        axi_rd(32'h0000_0040);
        `CHK(resp, `RBS_RESP_SLVERR)
        sp = 2'($urandom);
        scan_mode_pins = sp;
        tck(3);
        repeat (3) @(posedge core_clk);  // two-flop crossing to core side
        `CHK(test_rstn_q, 1'b0)
        test_rstn_driven = 1'b1;  // controller drives the pin high
        test_rstn_pin = 1'b1;
        tck(3);
        scan_mode_pins = ~sp;
        tck(2);
        repeat (3) @(posedge core_clk);
        `CHK(test_rstn_q, 1'b1)
        `CHK(scan_mode_q, sp)
        `CHK(boundary_scan_q, sp == `RBS_SCAN_BOUNDARY)
        $display("test no_boot_scan done");
        // rom boot, little endian prompt then big endian slow
        for (int k = 0; k < 2; k++) begin
            boot(`RBS_BOOT_ROM, k[0], 2'(k * 3));
            axi_wr(`RBS_ADDR_HOSTCTL, 32'h0000_0002);
            `CHK(resp, `RBS_RESP_OKAY)
            `CHK(cpu_stall_q, 1'b1)
            wait_run(20000);
            `CHK(cpu_run_q, 1'b1)
            for (int i = 0; i < 256; i++) begin
                for (int j = 0; j < 4; j++)
                    exp_w = k ? {exp_w[23:0], rom_exp(4 * i + j)}
                              : {rom_exp(4 * i + j), exp_w[31:8]};
                `CHK(i_mem.mem[i], exp_w)
            end
            $display("test rom_boot %0d done", k);
        end
        // host boot; late configuration changes must be ignored
        boot(`RBS_BOOT_HOST, 1'b0, 2'h0);
        sel = pci_boot_sel;
        boot_mode_cfg <= `RBS_BOOT_NONE;
        pci_boot_sel <= ~sel;
        irq_cnt = 0;
        repeat (20) @(posedge core_clk);
        `CHK(cpu_stall_q, 1'b1)
        `CHK(host_port_pci_q, sel)
        `CHK(host_mem_en_q, 1'b1)
        axi_wr(`RBS_ADDR_HOSTCTL, 32'h0000_0002);
        `CHK(resp, `RBS_RESP_OKAY)
        wait_run(10);
        `CHK(cpu_run_q, 1'b1)
        `CHK(irq_cnt, 0)
        axi_wr(`RBS_ADDR_HOSTCTL, 32'h0000_0002);
        `CHK(irq_cnt, 0)
        axi_wr(`RBS_ADDR_CTRL, 32'h0000_0001);
        axi_rd(`RBS_ADDR_HOSTCTL);
        `CHK(rd_val[1], 1'b0)
        axi_wr(`RBS_ADDR_HOSTCTL, 32'h0000_0002);
        repeat (2) @(posedge core_clk);
        `CHK(irq_cnt, 1)
        `CHK(host_mem_en_q, 1'b1)
        $display("test host_boot done");
        give_verdict();
    end
endmodule // rbs_top_tb
